// ### design/lar_pkg.sv
// Purpose: Shared constants for the link alarm and reset access port
// Assumes: One clock domain; control byte assembled once per hyperframe
// Notes: Byte bit positions follow the layer-1 control byte layout
package lar_pkg;

    // Register map, byte addresses on the APB side
    localparam logic [7:0] ADDR_STATUS = 8'h2c;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h30;
    localparam logic [7:0] ADDR_CONFIG = 8'h34;

    // Reset values
    localparam logic [31:0] TX_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

    // Control byte bit positions (also used in the tx control register)
    localparam int ZB_RESET = 0;
    localparam int ZB_RAI = 1;
    localparam int ZB_SDI = 2;
    localparam int ZB_LOS = 3;
    localparam int ZB_LOF = 4;
    localparam int ZBYTE_W = 8;

    // Status register fields
    localparam int ST_LOCAL_LOF = 0;
    localparam int ST_LOCAL_LOS = 1;
    localparam int ST_REMOTE_LOF = 2;
    localparam int ST_REMOTE_LOS = 3;
    localparam int ST_RAI_DETECTED = 4;
    localparam int ST_SDI_FORWARD = 5;
    localparam int ST_RESET_FORWARD = 6;
    localparam int ST_LOCAL_RAI = 7;

    // Configuration register fields
    localparam int CFG_RX_LOS_EN = 0;
    localparam int CFG_MASTER = 1;

    // Line code violation: more than this many bit errors per hyperframe
    localparam logic [4:0] LCV_ERR_LIMIT = 5'h0f;
    localparam int ERR_CNT_W = 5;

    // Layer-1 synchronisation state, one-hot
    typedef enum logic [3:0] {
        SYNC_STANDBY = 4'h1,
        ACQUIRE_STATE_ONE = 4'h2,
        ACQUIRE_STATE_TWO = 4'h4,
        SYNC_LOCKED = 4'h8
    } lar_sync_t;

endpackage

// ### design/lar_if.sv
// Purpose: Alarm and reset access port between link core and application
// Assumes: Both ends on the same core output clock
// Notes: Plain levels only, no handshake
`timescale 1ns/100ps
`default_nettype none
interface lar_if;
    logic near_frame_loss_out;
    logic near_signal_loss_out;
    logic near_alarm_out;
    logic far_frame_loss_out;
    logic far_signal_loss_out;
    logic far_alarm_out;
    logic sap_defect_forward_out;
    logic link_reset_forward_out;
    logic sap_defect_request_in;
    logic link_reset_request_in;

    modport device (
        output near_frame_loss_out, near_signal_loss_out, near_alarm_out,
        output far_frame_loss_out, far_signal_loss_out, far_alarm_out,
        output sap_defect_forward_out, link_reset_forward_out,
        input sap_defect_request_in, link_reset_request_in
    );

    modport app (
        input near_frame_loss_out, near_signal_loss_out, near_alarm_out,
        input far_frame_loss_out, far_signal_loss_out, far_alarm_out,
        input sap_defect_forward_out, link_reset_forward_out,
        output sap_defect_request_in, link_reset_request_in
    );
endinterface // lar_if
`default_nettype wire

// ### design/lar_device_end.sv
// Purpose: Link core end of the alarm and reset access port
// Assumes: tx_hf_start and rx_z_valid are one-cycle pulses per hyperframe
// Notes: Status and control reached over APB, zero wait states while ce is high
`timescale 1ns/100ps
`default_nettype none
module lar_device_end
    import lar_pkg::*;
#(
    parameter bit PORT_EN = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Alarm and reset access port
    lar_if.device link,
    // Link framing side
    input wire logic tx_hf_start,
    output logic [ZBYTE_W-1:0] tx_z_byte,
    input wire logic rx_z_valid,
    input wire logic [ZBYTE_W-1:0] rx_z_byte,
    input wire lar_sync_t sync_fsm_state,
    input wire logic code_err,
    input wire logic xcvr_los_pin,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    logic los_s1_reg;
    logic los_s2_reg;
    logic los_s3_reg;
    logic los_level_reg;
    logic [ERR_CNT_W-1:0] err_cnt_reg;
    logic lcv_reg;
    logic near_lof_reg;
    logic near_los_reg;
    logic near_rai;
    logic sdi_pend_reg;
    logic rst_pend_reg;
    logic sdi_req;
    logic rst_req;
    logic far_lof_reg;
    logic far_los_reg;
    logic far_sdi_reg;
    logic far_rst_reg;
    logic far_rai;
    logic [31:0] tx_ctrl_reg;
    logic [31:0] config_reg;
    logic [31:0] status;
    logic [31:0] rd_next;
    logic addr_ok;
    logic is_master;

    assign sdi_req = PORT_EN & link.sap_defect_request_in;
    assign rst_req = PORT_EN & link.link_reset_request_in;

    assign is_master = config_reg[CFG_MASTER];

    // Pin crosses in through three stages; second and third must agree
    always_ff @(posedge clk) begin
        if (srst) begin
            los_s1_reg <= 1'b0;
            los_s2_reg <= 1'b0;
            los_s3_reg <= 1'b0;
            los_level_reg <= 1'b0;
        end else if (ce) begin
            los_s1_reg <= xcvr_los_pin;
            los_s2_reg <= los_s1_reg;
            los_s3_reg <= los_s2_reg;
            if (los_s2_reg == los_s3_reg) begin
                los_level_reg <= los_s3_reg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            err_cnt_reg <= '0;
            lcv_reg <= 1'b0;
        end else if (ce) begin
            if (rx_z_valid) begin
                // Window closes; error arriving this cycle still counts
                lcv_reg <= ((err_cnt_reg + ERR_CNT_W'(code_err))
                            > LCV_ERR_LIMIT);
                err_cnt_reg <= '0;
            end else if (code_err && err_cnt_reg <= LCV_ERR_LIMIT) begin
                // Saturate just above the limit
                err_cnt_reg <= err_cnt_reg + 5'h01;
            end
        end
    end

    // Local indications
    always_ff @(posedge clk) begin
        if (srst) begin
            near_lof_reg <= 1'b0;
            near_los_reg <= 1'b0;
        end else if (ce) begin
            near_lof_reg <= (sync_fsm_state == ACQUIRE_STATE_ONE) ||
                            (sync_fsm_state == ACQUIRE_STATE_TWO);
            near_los_reg <= lcv_reg ||
                            (los_level_reg && config_reg[CFG_RX_LOS_EN]);
        end
    end

    assign near_rai = near_lof_reg | near_los_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            sdi_pend_reg <= 1'b0;
            rst_pend_reg <= 1'b0;
        end else if (ce) begin
            // A request in the assembly cycle survives into the next one
            sdi_pend_reg <= (sdi_pend_reg & ~tx_hf_start) | sdi_req;
            rst_pend_reg <= (rst_pend_reg & ~tx_hf_start) | rst_req;
        end
    end

    // Outgoing control byte, built once per hyperframe
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_z_byte <= '0;
        end else if (ce && tx_hf_start) begin
            tx_z_byte <= tx_ctrl_reg[ZBYTE_W-1:0];
            if (PORT_EN && near_lof_reg) begin
                tx_z_byte[ZB_LOF] <= 1'b1;
            end
            if (PORT_EN && near_los_reg) begin
                tx_z_byte[ZB_LOS] <= 1'b1;
            end
            if (PORT_EN && near_rai) begin
                tx_z_byte[ZB_RAI] <= 1'b1;
            end
            if (sdi_pend_reg || sdi_req) begin
                tx_z_byte[ZB_SDI] <= 1'b1;
            end
            if (rst_pend_reg || rst_req) begin
                tx_z_byte[ZB_RESET] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            far_lof_reg <= 1'b0;
            far_los_reg <= 1'b0;
            far_sdi_reg <= 1'b0;
            far_rst_reg <= 1'b0;
        end else if (ce && rx_z_valid) begin
            far_lof_reg <= rx_z_byte[ZB_LOF];
            far_los_reg <= rx_z_byte[ZB_LOS];
            // only a master sends defect indication
            far_sdi_reg <= rx_z_byte[ZB_SDI] & ~is_master;
            far_rst_reg <= rx_z_byte[ZB_RESET];
        end
    end

    assign far_rai = far_lof_reg | far_los_reg;

    // all port outputs, near-end and far-end, silent when option off
    assign link.near_frame_loss_out = PORT_EN & near_lof_reg;
    assign link.near_signal_loss_out = PORT_EN & near_los_reg;
    assign link.near_alarm_out = PORT_EN & near_rai;
    assign link.far_frame_loss_out = PORT_EN & far_lof_reg;
    assign link.far_signal_loss_out = PORT_EN & far_los_reg;
    assign link.far_alarm_out = PORT_EN & far_rai;
    assign link.sap_defect_forward_out = PORT_EN & far_sdi_reg;
    assign link.link_reset_forward_out = PORT_EN & far_rst_reg;

    always_comb begin
        status = '0;
        status[ST_LOCAL_LOF] = near_lof_reg;
        status[ST_LOCAL_LOS] = near_los_reg;
        status[ST_REMOTE_LOF] = far_lof_reg;
        status[ST_REMOTE_LOS] = far_los_reg;
        status[ST_RAI_DETECTED] = far_rai;
        status[ST_SDI_FORWARD] = far_sdi_reg;
        status[ST_RESET_FORWARD] = far_rst_reg;
        status[ST_LOCAL_RAI] = near_rai;
    end

    // APB decode
    always_comb begin
        addr_ok = 1'b1;
        rd_next = '0;
        case (paddr)
            ADDR_STATUS: rd_next = status;
            ADDR_TX_CTRL: rd_next = tx_ctrl_reg;
            ADDR_CONFIG: rd_next = config_reg;
            default: addr_ok = 1'b0;
        endcase
    end

    // Stalls while frozen so no write is lost; a read whose setup cycle is frozen returns old prdata
    assign pready = ce;
    assign pslverr = psel & penable & ~addr_ok;

    // Read data fetched during setup, stable through access
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= '0;
        end else if (ce && psel && !penable) begin
            prdata <= rd_next;
        end
    end

    // Writes take effect at the access edge; status is read-only
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_ctrl_reg <= TX_CTRL_RESET;
            config_reg <= CONFIG_RESET;
        end else if (ce && psel && penable && pwrite) begin
            if (paddr == ADDR_TX_CTRL) begin
                tx_ctrl_reg <= {24'h000000, 3'h0, pwdata[ZB_LOF:0]};
            end
            if (paddr == ADDR_CONFIG) begin
                config_reg <= {30'h0, pwdata[CFG_MASTER:0]};
            end
        end
    end

endmodule // lar_device_end
`default_nettype wire

// ### design/lar_app_end.sv
// Purpose: Application end of the alarm and reset access port
// Assumes: Same clock as the link core; user inputs are same-domain logic
// Notes: Chain inputs come from an upstream slave's forward outputs
`timescale 1ns/100ps
`default_nettype none
module lar_app_end
    import lar_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Alarm and reset access port
    lar_if.app link,
    // Requests from application and from an upstream hop
    input wire logic user_sap_defect,
    input wire logic user_reset_request,
    input wire logic chain_sap_defect,
    input wire logic chain_reset_request,
    // Indications to the application
    output logic [7:0] user_alarm_view
);

    // defect request, reset request, chain forward
    always_ff @(posedge clk) begin
        if (srst) begin
            link.sap_defect_request_in <= 1'b0;
            link.link_reset_request_in <= 1'b0;
        end else if (ce) begin
            link.sap_defect_request_in <= user_sap_defect | chain_sap_defect;
            link.link_reset_request_in <= user_reset_request |
                                          chain_reset_request;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            user_alarm_view <= 8'h00;
        end else if (ce) begin
            user_alarm_view <= {link.link_reset_forward_out,
                                link.sap_defect_forward_out,
                                link.far_alarm_out,
                                link.far_signal_loss_out,
                                link.far_frame_loss_out,
                                link.near_alarm_out,
                                link.near_signal_loss_out,
                                link.near_frame_loss_out};
        end
    end

endmodule // lar_app_end
`default_nettype wire

// ### test/lar_chk.sv
// Purpose: Assertions on the alarm and reset access port
// Assumes: One clock, srst synchronous active high
// Notes: Also watches the device framing ports
`timescale 1ns/100ps
`default_nettype none
module lar_chk
    import lar_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Port signals
    input wire logic near_frame_loss_out,
    input wire logic near_signal_loss_out,
    input wire logic near_alarm_out,
    input wire logic far_frame_loss_out,
    input wire logic far_signal_loss_out,
    input wire logic far_alarm_out,
    input wire logic sap_defect_forward_out,
    input wire logic link_reset_forward_out,
    input wire logic sap_defect_request_in,
    input wire logic link_reset_request_in,
    // Framing side
    input wire logic tx_hf_start,
    input wire logic [ZBYTE_W-1:0] tx_z_byte,
    input wire logic rx_z_valid,
    input wire logic [ZBYTE_W-1:0] rx_z_byte,
    input wire lar_sync_t sync_fsm_state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    wire logic rx_take = rx_z_valid & ce & ~srst;
    wire logic tx_take = tx_hf_start & ce & ~srst;
    wire logic acq = (sync_fsm_state == ACQUIRE_STATE_ONE) |
        (sync_fsm_state == ACQUIRE_STATE_TWO);

    chk_near_alarm_or: assert property (
        near_alarm_out == (near_frame_loss_out | near_signal_loss_out))
        else $error("near alarm differs from OR of losses");
    chk_far_alarm_or: assert property (
        far_alarm_out == (far_frame_loss_out | far_signal_loss_out))
        else $error("far alarm differs from OR of losses");
    chk_far_lof_take: assert property (
        rx_take |=> far_frame_loss_out == $past(rx_z_byte[ZB_LOF]))
        else $error("far frame loss not taken from byte");
    chk_far_los_take: assert property (
        rx_take |=> far_signal_loss_out == $past(rx_z_byte[ZB_LOS]))
        else $error("far signal loss not taken from byte");
    chk_reset_fwd_take: assert property (
        rx_take |=> link_reset_forward_out == $past(rx_z_byte[ZB_RESET]))
        else $error("reset forward not taken from byte");
    chk_sdi_fwd_clear: assert property (
        rx_take && !rx_z_byte[ZB_SDI] |=> !sap_defect_forward_out)
        else $error("defect forward without received bit");
    chk_far_hold_frame: assert property (
        !srst && !rx_take |=> $stable({far_frame_loss_out,
        far_signal_loss_out, link_reset_forward_out}))
        else $error("far outputs changed between hyperframes");
    chk_near_lof_acq: assert property (
        !srst && ce |=> near_frame_loss_out == $past(acq))
        else $error("near frame loss not following acquisition");
    chk_tx_local_bits: assert property (
        tx_take |=> (tx_z_byte[ZB_LOF] || !$past(near_frame_loss_out)) &&
        (tx_z_byte[ZB_LOS] || !$past(near_signal_loss_out)) &&
        (tx_z_byte[ZB_RAI] || !$past(near_alarm_out)))
        else $error("local indication missing from byte");
    chk_tx_request_bits: assert property (
        tx_take |=> (tx_z_byte[ZB_SDI] || !$past(sap_defect_request_in)) &&
        (tx_z_byte[ZB_RESET] || !$past(link_reset_request_in)))
        else $error("request missing from byte");
    chk_tx_byte_hold: assert property (
        !srst && !tx_take |=> $stable(tx_z_byte))
        else $error("outgoing byte changed between hyperframes");

    cover property (rx_take && rx_z_byte[ZB_LOF]);
    cover property (tx_take && sap_defect_request_in);
    cover property ($rose(near_signal_loss_out));
endmodule // lar_chk
`default_nettype wire

// ### test/test_link_alarm_reset_access.sv
// Purpose: Self-checking bench for both ends of the alarm access port
// Assumes: ce high except in the freeze test; requests stick a hyperframe
// Notes: Expected values come from a small integer model
`timescale 1ns/100ps
`default_nettype none
module test_link_alarm_reset_access;
    import lar_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic tx_hf_start = 1'b0;
    logic rx_z_valid = 1'b0;
    logic [7:0] rx_z_byte = 8'h00;
    logic [7:0] tx_z_byte;
    lar_sync_t sync_fsm_state = SYNC_LOCKED;
    logic code_err = 1'b0;
    logic xcvr_los_pin = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] req = 4'h0;
    logic [7:0] user_alarm_view;
    logic [7:0] ev;
    logic [31:0] rd;
    logic err;
    logic acq;
    logic [1:0] prev;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 20;
    int r;

    lar_if u_lar_if ();
    wire logic [7:0] port_view = {u_lar_if.link_reset_forward_out,
        u_lar_if.sap_defect_forward_out, u_lar_if.far_alarm_out,
        u_lar_if.far_signal_loss_out, u_lar_if.far_frame_loss_out,
        u_lar_if.near_alarm_out, u_lar_if.near_signal_loss_out,
        u_lar_if.near_frame_loss_out};
    lar_device_end u_lar_device_end (.clk(clk), .srst(srst), .ce(ce),
        .link(u_lar_if), .tx_hf_start(tx_hf_start), .tx_z_byte(tx_z_byte),
        .rx_z_valid(rx_z_valid), .rx_z_byte(rx_z_byte),
        .sync_fsm_state(sync_fsm_state), .code_err(code_err),
        .xcvr_los_pin(xcvr_los_pin), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    lar_app_end u_lar_app_end (.clk(clk), .srst(srst), .ce(ce),
        .link(u_lar_if), .user_sap_defect(req[0]),
        .user_reset_request(req[1]), .chain_sap_defect(req[2]),
        .chain_reset_request(req[3]), .user_alarm_view(user_alarm_view));
    lar_chk u_lar_chk (.clk(clk), .srst(srst), .ce(ce),
        .near_frame_loss_out(u_lar_if.near_frame_loss_out),
        .near_signal_loss_out(u_lar_if.near_signal_loss_out),
        .near_alarm_out(u_lar_if.near_alarm_out),
        .far_frame_loss_out(u_lar_if.far_frame_loss_out),
        .far_signal_loss_out(u_lar_if.far_signal_loss_out),
        .far_alarm_out(u_lar_if.far_alarm_out),
        .sap_defect_forward_out(u_lar_if.sap_defect_forward_out),
        .link_reset_forward_out(u_lar_if.link_reset_forward_out),
        .sap_defect_request_in(u_lar_if.sap_defect_request_in),
        .link_reset_request_in(u_lar_if.link_reset_request_in),
        .tx_hf_start(tx_hf_start), .tx_z_byte(tx_z_byte),
        .rx_z_valid(rx_z_valid), .rx_z_byte(rx_z_byte),
        .sync_fsm_state(sync_fsm_state));

    always #12.5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("unexpected at %0t: no bus answer", $time);
            mismatches++;
            end_of_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic send_rx(input logic [7:0] b);
        @(posedge clk);
        rx_z_valid <= 1'b1;
        rx_z_byte <= b;
        @(posedge clk);
        rx_z_valid <= 1'b0;
        rx_z_byte <= ~b;
        @(posedge clk);
    endtask

    task automatic send_tx();
        @(posedge clk);
        tx_hf_start <= 1'b1;
        @(posedge clk);
        tx_hf_start <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        tick(4);
        srst <= 1'b0;
        apb(1'b0, ADDR_TX_CTRL, 32'h0);
        check(rd, TX_CTRL_RESET);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        check(rd, CONFIG_RESET);
        apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("register test done");
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            apb(1'b1, ADDR_CONFIG, {30'h0, r[8], 1'b0});
            send_rx(r[7:0]);
            ev = {r[0], r[2] & ~r[8], r[4] | r[3], r[3], r[4], 3'h0};
            check(32'(port_view), 32'(ev));
            @(posedge clk);
            check(32'(user_alarm_view), 32'(ev));
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(rd, {25'h0, ev[7:3], 2'h0});
        end
        $display("receive test done");
        prev = 2'h0;
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            sync_fsm_state <= lar_sync_t'(4'h1 << r[1:0]);
            req <= r[7:4];
            acq = (r[1:0] == 2'h1) || (r[1:0] == 2'h2);
            apb(1'b1, ADDR_TX_CTRL, {27'h0, r[12:8]});
            send_tx();
            ev = {3'h0, acq | r[12], r[11], r[4] | r[6] | prev[0] | r[10],
                acq | r[9], r[5] | r[7] | prev[1] | r[8]};
            check(32'(tx_z_byte), 32'(ev));
            prev = {r[5] | r[7], r[4] | r[6]};
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(rd & 32'h83, {24'h0, acq, 6'h0, acq});
        end
        req <= 4'h0;
        apb(1'b1, ADDR_TX_CTRL, 32'h0);
        send_tx();
        req <= 4'h1;
        @(posedge clk);
        req <= 4'h0;
        tick(4);
        send_tx();
        check(32'(tx_z_byte[ZB_SDI]), 32'h1);
        send_tx();
        check(32'(tx_z_byte[ZB_SDI]), 32'h0);
        $display("transmit test done");
        sync_fsm_state <= SYNC_LOCKED;
        apb(1'b1, ADDR_CONFIG, 32'h1);
        xcvr_los_pin <= 1'b1;
        tick(8);
        check(32'(port_view[2:0]), 32'h6);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd & 32'h83, 32'h82);
        apb(1'b1, ADDR_CONFIG, 32'h0);
        tick(3);
        check(32'(port_view[2:0]), 32'h0);
        for (int n = 15; n < 17; n++) begin
            send_rx(8'h00);
            repeat (n) begin
                @(posedge clk);
                code_err <= 1'b1;
            end
            @(posedge clk);
            code_err <= 1'b0;
            send_rx(8'h00);
            @(posedge clk);
            check(32'(port_view[2:0]), (n > 15) ? 32'h6 : 32'h0);
        end
        $display("signal loss test done");
        // Frozen core must ignore a received byte
        ce <= 1'b0;
        send_rx(8'h10);
        check(32'(port_view), 32'h6);
        ce <= 1'b1;
        $display("freeze test done");
        end_of_test();
    end
endmodule // test_link_alarm_reset_access
`default_nettype wire
